//--- sim/adc_output_range_flag_bench.sv
module adc_output_range_flag_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import aorf_pkg::*;

   // ====
   // Signals and instances
   logic                    clk_i = 1'b0;
   logic                    rst_n_i = 1'b0;
   logic                    run_i = 1'b0;
   logic                    ref_disturb_i = 1'b0;
   logic [HALF_W-1:0]       half_period_i = 12'h011;
   logic signed [ANA_W-1:0] analog_i = 16'sh0000;
   aorf_range_t             range_sel_i = RANGE_UNI_2V5;
   logic [DATA_W-1:0]       sample_o;
   logic [DATA_W-1:0]       twos_o;
   logic                    in_range_o;
   logic                    under_o;
   logic                    over_o;
   logic                    sample_strobe_o;
   logic                    word_valid_o;
   logic                    stalled_o;
   logic [12:0]             notes[$];
   int                      n_fail = 0;
   int                      num_checks = 0;

   aorf_link_if link ();
   aorf_host aorf_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .run_i(run_i),
      .half_period_i(half_period_i), .sample_o(sample_o), .twos_o(twos_o),
      .in_range_o(in_range_o), .under_o(under_o), .over_o(over_o),
      .sample_strobe_o(sample_strobe_o));
   aorf_device aorf_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
      .analog_i(analog_i), .range_sel_i(range_sel_i), .ref_disturb_i(ref_disturb_i),
      .word_valid_o(word_valid_o), .clock_stalled_o(stalled_o));
   aorf_link_monitor aorf_link_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .sample_clk(link.sample_clk), .data(link.data),
      .range_exceeded_flag(link.range_exceeded_flag));

   always #5 clk_i = ~clk_i;

   // ====
   // Helpers
   function automatic logic [12:0] expect_word(int v, aorf_range_t r);
      int n;
      if (r == RANGE_BIP_2V5)
         n = (v + int'(BIP_OFFSET) + int'(HALF_STEP_2)) >>> SHIFT_5V0;
      else if (r == RANGE_UNI_5V0)
         n = (v + int'(HALF_STEP_2)) >>> SHIFT_5V0;
      else
         n = (v + int'(HALF_STEP_1)) >>> SHIFT_2V5;
      if (n < 0)
         return {1'b1, CODE_MIN};
      if (n > int'(CODE_MAX))
         return {1'b1, CODE_MAX};
      return {1'b0, n[11:0]};
   endfunction

   task automatic check(input logic [12:0] seen, input logic [12:0] want);
      num_checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wait_strobe();
      for (int k = 0; k < 6000; k++)
      begin
         @(negedge clk_i);
         if (sample_strobe_o === 1'b1)
            return;
      end
      n_fail++;
      wrap_up();
   endtask

   // ====
   // Result watcher: word of a sample shows three strobes later
   always @(posedge clk_i)
   begin
      #1;
      if (sample_strobe_o === 1'b1 && notes.size() >= 3)
      begin : watch
         logic [12:0] w;
         w = notes.pop_front();
         if (word_valid_o === 1'b1)
         begin
            check({1'b0, sample_o}, {1'b0, w[11:0]});
            check({1'b0, twos_o}, {1'b0, ~w[11], w[10:0]});
            check({10'h000, in_range_o, under_o, over_o},
               {10'h000, ~w[12], w[12] & ~w[11], w[12] & w[11]});
         end
      end
   end

   // ====
   // Stimulus
   initial
   begin
      int          v;
      aorf_range_t r;
      int          edges [4];
      edges = '{-32'sh2003, 32'sh0000, 32'sh1ffe, 32'sh3ffe};
      v = $urandom(89382);
      repeat (8) @(negedge clk_i);
      rst_n_i = 1'b1;
      run_i = 1'b1;
      for (int i = 0; i < 120; i++)
      begin
         wait_strobe();
         check({12'h000, stalled_o}, 13'h0000);
         if (i == 61)
            check({12'h000, word_valid_o}, 13'h0000);
         r = aorf_range_t'($urandom_range(3, 0));
         if ($urandom_range(1, 0) == 1)
            v = int'($urandom_range(17000, 0)) - 8600;
         else
            v = edges[$urandom_range(3, 0)] + int'($urandom_range(6, 0)) - 3;
         // Two periods at the slowest clock the host allows
         if (i == 110 || i == 111)
            half_period_i = 12'hfff;
         else
            half_period_i = (i % 16 == 5) ? 12'h005 : 12'h011 + 12'($urandom_range(13, 0));
         analog_i = 16'(v);
         range_sel_i = r;
         notes.push_back(expect_word(v, r));
         ref_disturb_i = (i == 60);
      end
      check({12'h000, word_valid_o}, 13'h0001);
      run_i = 1'b0;
      for (int k = 0; k < 3000 && stalled_o !== 1'b1; k++)
         @(negedge clk_i);
      check({12'h000, stalled_o}, 13'h0001);
      check({12'h000, word_valid_o}, 13'h0000);
      wrap_up();
   end
endmodule

//--- sim/aorf_link_monitor.sv
module aorf_link_monitor
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        sample_clk,
   input  wire logic [aorf_pkg::DATA_W-1:0] data,
   input  wire logic                        range_exceeded_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   import aorf_pkg::*;

   // ====
   // Phase length of the sampling clock
   logic             sclk_reg;
   logic             sclk_next;
   logic             primed_reg;
   logic             primed_next;
   logic [CNT_W-1:0] run_reg;
   logic [CNT_W-1:0] run_next;
   logic             edge_seen;

   always_comb
   begin
      edge_seen   = (sample_clk != sclk_reg);
      sclk_next   = sample_clk;
      primed_next = primed_reg | edge_seen;
      run_next    = edge_seen ? 12'h001 : (&run_reg ? run_reg : run_reg + 12'h001);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sclk_reg   <= SCLK_RST;
         primed_reg <= 1'b0;
         run_reg    <= 12'h000;
      end
      else
      begin
         sclk_reg   <= sclk_next;
         primed_reg <= primed_next;
         run_reg    <= run_next;
      end
   end

   // ====
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_high_min: assert property (
      primed_reg && edge_seen && !sample_clk |-> run_reg >= HALF_MIN_CYC)
      else $error("sample clock high phase too short");
   a_low_min: assert property (
      primed_reg && edge_seen && sample_clk |-> run_reg >= HALF_MIN_CYC)
      else $error("sample clock low phase too short");
   a_high_max: assert property (
      primed_reg && edge_seen && !sample_clk |-> run_reg <= HALF_MAX_CYC)
      else $error("sample clock high phase too long");
   a_word_timing: assert property (
      $changed(data) |-> $past(sample_clk, 4) && !$past(sample_clk, 3))
      else $error("data word moved away from the clock fall");
   a_flag_timing: assert property (
      $changed(range_exceeded_flag) |-> $past(sample_clk, 4) && !$past(sample_clk, 3))
      else $error("flag moved apart from its data word");
   a_word_hold: assert property (
      $changed(data) |=> $stable(data) [*8])
      else $error("data word did not stand");
   a_high_steady: assert property (
      $rose(sample_clk) |=> $stable({range_exceeded_flag, data}) [*8])
      else $error("output changed in the clock high phase");
   a_flag_code: assert property (
      range_exceeded_flag |-> data == CODE_MIN || data == CODE_MAX)
      else $error("flag set with a code inside the scale");

   c_over: cover property (range_exceeded_flag && data == CODE_MAX);
   c_under: cover property (range_exceeded_flag && data == CODE_MIN);
   c_clear: cover property ($fell(range_exceeded_flag));
   c_slow: cover property (primed_reg && edge_seen && run_reg == HALF_MAX_CYC);
endmodule

//--- verilog/aorf_device.sv
// Operation
// - Unipolar ranges give straight binary codes
// - Bipolar range gives offset binary codes
// - Receiver inverts MSB for twos complement
// - Flag travels with its data word
// - Flag low for in-range samples
// - Flag high beyond half LSB past full-scale
// - Flag stays high until in-range sample output
// - Receiver decodes under/over from flag and MSB
// - Both sample clock edges drive conversion timing
// - Clock high and low phases meet minimum
// - Even duty cycle at maximum rate
// - Uneven duty allowed below maximum rate
// - Even duty from divide-by-two of faster clock
// - Converts correctly down to minimum clock rate
// - Three conversions in flight; disturbance flushes
module aorf_device
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   aorf_link_if.dev                       link,
   input  wire logic signed [aorf_pkg::ANA_W-1:0] analog_i,
   input  wire aorf_pkg::aorf_range_t     range_sel_i,
   input  wire logic                      ref_disturb_i,
   output logic                           word_valid_o,
   output logic                           clock_stalled_o
);
   import aorf_pkg::*;

   // ==========================================================
   // Quantiser: returns {flag, code}
   function automatic logic [DATA_W:0] aorf_quantize
   (
      input logic signed [ANA_W-1:0] v,
      input aorf_range_t             r
   );
      logic signed [17:0] off;
      logic signed [17:0] n;
      off = 18'(v);
      case (r)
         RANGE_BIP_2V5:
         begin
            off = 18'(v) + BIP_OFFSET;
            n   = (off + HALF_STEP_2) >>> SHIFT_5V0;
         end
         RANGE_UNI_5V0:
         begin
            n = (off + HALF_STEP_2) >>> SHIFT_5V0;
         end
         default:
         begin
            n = (off + HALF_STEP_1) >>> SHIFT_2V5;
         end
      endcase
      if (n < 18'sh00000)
         aorf_quantize = {1'b1, CODE_MIN};
      else if (n > CODE_TOP)
         aorf_quantize = {1'b1, CODE_MAX};
      else
         aorf_quantize = {1'b0, n[DATA_W-1:0]};
   endfunction

   // ==========================================================
   // Sample clock synchroniser and edge detect
   logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
   logic rise, fall;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sclk_s1_reg <= SCLK_RST;
         sclk_s2_reg <= SCLK_RST;
         sclk_s3_reg <= SCLK_RST;
      end
      else
      begin
         sclk_s1_reg <= link.sample_clk;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
      end
   end

   assign rise = sclk_s2_reg & ~sclk_s3_reg;
   assign fall = ~sclk_s2_reg & sclk_s3_reg;

   // ==========================================================
   // Slow clock watchdog
   logic [CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
   logic             stalled_reg, stalled_next;
   logic             flush;

   always_comb
   begin
      idle_cnt_next = idle_cnt_reg;
      stalled_next  = stalled_reg;
      if (rise || fall)
      begin
         idle_cnt_next = 12'h000;
         stalled_next  = 1'b0;
      end
      else if (idle_cnt_reg >= CNT_W'(STALL_CYC))
         stalled_next = 1'b1;
      else
         idle_cnt_next = idle_cnt_reg + 12'h001;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         idle_cnt_reg <= 12'h000;
         stalled_reg  <= 1'b0;
      end
      else
      begin
         idle_cnt_reg <= idle_cnt_next;
         stalled_reg  <= stalled_next;
      end
   end

   // Reference disturbance or lost clock empties the pipeline
   assign flush = ref_disturb_i | stalled_next;

   // ==========================================================
   // Conversion pipeline
   logic [DATA_W:0] stage_reg  [PIPE_DEPTH];
   logic [DATA_W:0] stage_next [PIPE_DEPTH];
   logic            vld_reg    [PIPE_DEPTH];
   logic            vld_next   [PIPE_DEPTH];

   always_comb
   begin
      stage_next[0] = stage_reg[0];
      vld_next[0]   = vld_reg[0] & ~flush;
      if (rise)
      begin
         stage_next[0] = aorf_quantize(analog_i, range_sel_i);
         vld_next[0]   = ~flush;
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi < PIPE_DEPTH; gi++)
      begin : g_stage
         always_comb
         begin
            stage_next[gi] = stage_reg[gi];
            vld_next[gi]   = vld_reg[gi] & ~flush;
            if (fall)
            begin
               stage_next[gi] = stage_reg[gi-1];
               vld_next[gi]   = vld_reg[gi-1] & ~flush;
            end
         end
      end
   endgenerate

   generate
      for (gi = 0; gi < PIPE_DEPTH; gi++)
      begin : g_stage_ff
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               stage_reg[gi] <= {FLAG_RST, DATA_RST};
               vld_reg[gi]   <= 1'b0;
            end
            else
            begin
               stage_reg[gi] <= stage_next[gi];
               vld_reg[gi]   <= vld_next[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Output word
   logic [DATA_W-1:0] data_reg, data_next;
   logic              flag_reg, flag_next;
   logic              wvld_reg, wvld_next;

   always_comb
   begin
      data_next = data_reg;
      flag_next = flag_reg;
      wvld_next = wvld_reg & ~flush;
      if (fall)
      begin
         data_next = stage_reg[PIPE_DEPTH-1][DATA_W-1:0];
         flag_next = stage_reg[PIPE_DEPTH-1][DATA_W];
         wvld_next = vld_reg[PIPE_DEPTH-1] & ~flush;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         data_reg <= DATA_RST;
         flag_reg <= FLAG_RST;
         wvld_reg <= 1'b0;
      end
      else
      begin
         data_reg <= data_next;
         flag_reg <= flag_next;
         wvld_reg <= wvld_next;
      end
   end

   assign link.data                = data_reg;
   assign link.range_exceeded_flag = flag_reg;
   assign word_valid_o             = wvld_reg;
   assign clock_stalled_o          = stalled_reg;
endmodule

//--- verilog/aorf_host.sv
module aorf_host
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   aorf_link_if.host                        link,
   input  wire logic                        run_i,
   input  wire logic [aorf_pkg::HALF_W-1:0] half_period_i,
   output logic [aorf_pkg::DATA_W-1:0]      sample_o,
   output logic [aorf_pkg::DATA_W-1:0]      twos_o,
   output logic                             in_range_o,
   output logic                             under_o,
   output logic                             over_o,
   output logic                             sample_strobe_o
);
   import aorf_pkg::*;

   // ==========================================================
   // Clock generation
   logic [CNT_W-1:0]  tick_cnt_reg, tick_cnt_next;
   logic [HALF_W-1:0] half_reg, half_next;
   logic              sclk_reg, sclk_next;
   logic [HALF_W-1:0] half_clamped;
   logic              tick;

   always_comb
   begin
      if (half_period_i < HALF_W'(HALF_MIN_CYC))
         half_clamped = HALF_W'(HALF_MIN_CYC);
      else if (half_period_i > HALF_W'(HALF_MAX_CYC))
         half_clamped = HALF_W'(HALF_MAX_CYC);
      else
         half_clamped = half_period_i;
   end

   assign tick = (tick_cnt_reg >= half_reg - 12'h001);

   always_comb
   begin
      tick_cnt_next = tick_cnt_reg + 12'h001;
      half_next     = half_reg;
      sclk_next     = sclk_reg;
      if (!run_i && !sclk_reg)
      begin
         tick_cnt_next = 12'h000;
         half_next     = half_clamped;
      end
      else if (tick)
      begin
         tick_cnt_next = 12'h000;
         sclk_next     = ~sclk_reg;
         half_next     = half_clamped;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tick_cnt_reg <= 12'h000;
         half_reg     <= HALF_W'(HALF_MIN_CYC);
         sclk_reg     <= SCLK_RST;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_next;
         half_reg     <= half_next;
         sclk_reg     <= sclk_next;
      end
   end

   assign link.sample_clk = sclk_reg;

   // ==========================================================
   // Capture and decode
   logic [DATA_W:0] sync1_reg, sync2_reg;
   logic [DATA_W-1:0] sample_reg, sample_next, twos_reg, twos_next;
   logic in_reg, in_next, under_reg, under_next, over_reg, over_next;
   logic strobe_reg, strobe_next;
   logic capture;

   assign capture = tick && !sclk_reg && run_i;

   always_comb
   begin
      sample_next = sample_reg;
      twos_next   = twos_reg;
      in_next     = in_reg;
      under_next  = under_reg;
      over_next   = over_reg;
      strobe_next = 1'b0;
      if (capture)
      begin
         sample_next = sync2_reg[DATA_W-1:0];
         twos_next   = {~sync2_reg[DATA_W-1], sync2_reg[DATA_W-2:0]};
         in_next     = ~sync2_reg[DATA_W];
         under_next  = sync2_reg[DATA_W] & ~sync2_reg[DATA_W-1];
         over_next   = sync2_reg[DATA_W] & sync2_reg[DATA_W-1];
         strobe_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync1_reg  <= 13'h0000;
         sync2_reg  <= 13'h0000;
         sample_reg <= DATA_RST;
         twos_reg   <= DATA_RST;
         in_reg     <= 1'b0;
         under_reg  <= 1'b0;
         over_reg   <= 1'b0;
         strobe_reg <= 1'b0;
      end
      else
      begin
         sync1_reg  <= {link.range_exceeded_flag, link.data};
         sync2_reg  <= sync1_reg;
         sample_reg <= sample_next;
         twos_reg   <= twos_next;
         in_reg     <= in_next;
         under_reg  <= under_next;
         over_reg   <= over_next;
         strobe_reg <= strobe_next;
      end
   end

   assign sample_o        = sample_reg;
   assign twos_o          = twos_reg;
   assign in_range_o      = in_reg;
   assign under_o         = under_reg;
   assign over_o          = over_reg;
   assign sample_strobe_o = strobe_reg;
endmodule

//--- verilog/aorf_link_if.sv
interface aorf_link_if;
   logic                       sample_clk;
   logic [aorf_pkg::DATA_W-1:0] data;
   logic                       range_exceeded_flag;

   modport dev
   (
      input  sample_clk,
      output data,
      output range_exceeded_flag
   );

   modport host
   (
      output sample_clk,
      input  data,
      input  range_exceeded_flag
   );
endinterface

//--- verilog/aorf_pkg.sv
package aorf_pkg;
   // ==========================================================
   // Widths
   localparam int DATA_W   = 12;
   localparam int ANA_W    = 16;
   localparam int HALF_W   = 12;
   localparam int CNT_W    = 12;

   // ==========================================================
   // Codes and reset values
   localparam logic [DATA_W-1:0] CODE_MIN  = 12'h000;
   localparam logic [DATA_W-1:0] CODE_MAX  = 12'hfff;
   localparam logic [DATA_W-1:0] DATA_RST  = 12'h000;
   localparam logic              FLAG_RST  = 1'b0;
   localparam logic              SCLK_RST  = 1'b0;

   // ==========================================================
   // Analog scale: one unit is half the LSB of the 2.5 V range
   localparam logic signed [17:0] BIP_OFFSET  = 18'sh02000;
   localparam logic signed [17:0] HALF_STEP_1 = 18'sh00001;
   localparam logic signed [17:0] HALF_STEP_2 = 18'sh00002;
   localparam logic signed [17:0] CODE_TOP    = 18'sh00fff;
   localparam int                 SHIFT_2V5   = 1;
   localparam int                 SHIFT_5V0   = 2;

   typedef enum logic [1:0]
   {
      RANGE_UNI_2V5 = 2'h0,
      RANGE_UNI_5V0 = 2'h1,
      RANGE_BIP_2V5 = 2'h2
   } aorf_range_t;

   // ==========================================================
   // Pipeline
   localparam int PIPE_DEPTH = 3;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int T_PULSE_MIN_NS = 167;
   localparam int F_SAMPLE_MIN_HZ = 20000;
   localparam int T_HALF_MAX_NS  = 1000000000 / (2 * F_SAMPLE_MIN_HZ);
   localparam int HALF_MIN_CYC   = (T_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALF_MAX_CYC   = T_HALF_MAX_NS / CLK_PERIOD_NS;
   localparam int STALL_MARGIN_CYC = 16;
   localparam int STALL_CYC      = HALF_MAX_CYC + STALL_MARGIN_CYC;
endpackage
